// *** logic/ddc_preset_pkg.sv ***
// Constants, register map and carrier types for the preset select block.
// Assumes a 32-bit APB slave with word-aligned registers.
package ddc_preset_pkg;

    // ------------------------------------------------------------------
    // Register indices and byte addresses
    // ------------------------------------------------------------------
    localparam logic [11:0] PRESET_SOURCE_CONTROL_IDX = 12'h20c;
    localparam logic [11:0] PRESET_INDEX_SELECT_IDX = 12'h20d;
    localparam logic [11:0] RATIONAL_STEP_DIVISOR_IDX = 12'h20e;
    localparam logic [11:0] PRESET_STATUS_IDX = 12'h210;
    localparam logic [11:0] PRESET_SOURCE_CONTROL_ADDR =
        {PRESET_SOURCE_CONTROL_IDX[9:0], 2'b00};
    localparam logic [11:0] PRESET_INDEX_SELECT_ADDR =
        {PRESET_INDEX_SELECT_IDX[9:0], 2'b00};
    localparam logic [11:0] RATIONAL_STEP_DIVISOR_ADDR =
        {RATIONAL_STEP_DIVISOR_IDX[9:0], 2'b00};
    localparam logic [11:0] PRESET_STATUS_ADDR =
        {PRESET_STATUS_IDX[9:0], 2'b00};

    // ------------------------------------------------------------------
    // Field positions, widths and reset values
    // ------------------------------------------------------------------
    localparam int SOURCE_BIT = 0;
    localparam int INDEX_W = 3;
    localparam int DIVISOR_W = 16;
    localparam int FREQ_W = 32;
    localparam int PHASE_W = 16;
    localparam int DELAY_W = 8;
    localparam int PRESET_COUNT = 8;
    localparam int STATUS_ACTIVE_LSB = 0;
    localparam int STATUS_UNSURE_BIT = 3;
    localparam int STATUS_DIVHIGH_BIT = 4;
    localparam logic SOURCE_RESET = 1'b0;
    localparam logic [2:0] INDEX_RESET = 3'h0;
    localparam logic [15:0] DIVISOR_RESET = 16'h0000;
    localparam logic [15:0] DIVISOR_LIMIT = 16'h2000;

    // ------------------------------------------------------------------
    // Carrier types
    // ------------------------------------------------------------------
    typedef logic [INDEX_W-1:0] presetIdx_t;

    typedef struct packed {
        logic [FREQ_W-1:0] frequencyWord;
        logic [PHASE_W-1:0] phaseOffset;
        logic [DELAY_W-1:0] downconverterDelay;
    } presetCfg_t;

    typedef struct packed {
        logic [FREQ_W-1:0] frequencyWord;
        logic [FREQ_W-1:0] phaseOffset;
        logic [DELAY_W-1:0] downconverterDelay;
    } activeCfg_t;

endpackage

// *** logic/ddc_preset_select_config.sv ***
// Preset source/index selection and the shared rational step divisor.
// Assumes an APB master on mclk; preset tables and the serial link
// live elsewhere and are joined through plain ports.
`timescale 1ns/1ps

// Behaviour
// - Source bit 0: active preset comes from the three select pins.
// - Source bit 1: active preset comes from the software index.
// - Eight presets 0..7; frequency and phase follow the active one.
// - Down-converter delay follows the active preset.
// - Software index is bits 2-0, reset 000, used when source is 1.
// - One 16-bit step divisor in bits 15-0, shared by all presets.
// - Frequency word is 32 bits; divisor gives exact steps.
// - 16-bit phase offset is MSB-justified into a 32-bit word.
// - Frequency change while link runs leaves phase non-deterministic.
module ddc_preset_select_config #(
    parameter int ADDR_W = 12
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [2:0] presetSelectPins,
    input wire logic linkRunning,
    input wire ddc_preset_pkg::presetCfg_t presetTable [8],
    output ddc_preset_pkg::presetIdx_t activePreset,
    output ddc_preset_pkg::activeCfg_t activeCfg,
    output logic [15:0] rationalStepDivisor
);

    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------
    // Shared by the write path, the read path and the error answer
    function automatic logic [2:0] decodeReg(input logic [ADDR_W-1:0] a);
        logic [2:0] sel;
        sel = 3'h0;
        case (a)
            ADDR_W'(ddc_preset_pkg::PRESET_SOURCE_CONTROL_ADDR): sel = 3'h1;
            ADDR_W'(ddc_preset_pkg::PRESET_INDEX_SELECT_ADDR): sel = 3'h2;
            ADDR_W'(ddc_preset_pkg::RATIONAL_STEP_DIVISOR_ADDR): sel = 3'h3;
            ADDR_W'(ddc_preset_pkg::PRESET_STATUS_ADDR): sel = 3'h4;
            default: sel = 3'h0;
        endcase
        return sel;
    endfunction

    logic [2:0] regSel;
    logic accessPhase;
    logic setupPhase;
    logic wrEn;

    // Zero-wait slave; unmapped addresses answer with an error
    assign regSel = decodeReg(paddr);
    assign setupPhase = psel && !penable;
    assign accessPhase = psel && penable;
    assign wrEn = accessPhase && pwrite && (regSel != 3'h0);
    assign pready = 1'b1;
    assign pslverr = accessPhase && (regSel == 3'h0);

    // ------------------------------------------------------------------
    // Pin synchroniser and control registers
    // ------------------------------------------------------------------
    logic [2:0] pinMeta_q, pinSync_q;
    logic presetSource_q, presetSource_d;
    ddc_preset_pkg::presetIdx_t presetIndex_q, presetIndex_d;
    logic [15:0] divisor_q, divisor_d;
    ddc_preset_pkg::presetIdx_t active_q, active_d;
    ddc_preset_pkg::activeCfg_t cfg_q, cfg_d;
    logic unsure_q, unsure_d;
    logic [31:0] rdata_q, rdata_d;
    logic freqChange;

    // Next values: byte lane 0 carries the 8-bit fields
    always_comb begin
        presetSource_d = presetSource_q;
        presetIndex_d = presetIndex_q;
        divisor_d = divisor_q;
        if (wrEn && regSel == 3'h1 && pstrb[0]) begin
            presetSource_d = pwdata[ddc_preset_pkg::SOURCE_BIT];
        end
        if (wrEn && regSel == 3'h2 && pstrb[0]) begin
            presetIndex_d = pwdata[2:0];
        end
        if (wrEn && regSel == 3'h3) begin
            if (pstrb[0]) begin
                divisor_d[7:0] = pwdata[7:0];
            end
            if (pstrb[1]) begin
                divisor_d[15:8] = pwdata[15:8];
            end
        end
    end

    // Source mux; a pin change reaches active_q three edges after it lands
    always_comb begin
        if (presetSource_q) begin
            active_d = presetIndex_q;
        end else begin
            active_d = pinSync_q;
        end
    end

    // Pick the active preset; phase is MSB-justified for the accumulator
    always_comb begin
        cfg_d.frequencyWord =
            presetTable[active_q].frequencyWord;
        cfg_d.phaseOffset = {presetTable[active_q].phaseOffset,
            16'h0000};
        cfg_d.downconverterDelay =
            presetTable[active_q].downconverterDelay;
    end

    // Sticky flag: a new frequency while the link runs spoils phase;
    // set wins over a same-cycle write-one-to-clear
    assign freqChange = cfg_d.frequencyWord != cfg_q.frequencyWord;
    always_comb begin
        unsure_d = unsure_q;
        if (wrEn && regSel == 3'h4 && pstrb[0]
            && pwdata[ddc_preset_pkg::STATUS_UNSURE_BIT]) begin
            unsure_d = 1'b0;
        end
        if (linkRunning && freqChange) begin
            unsure_d = 1'b1;
        end
    end

    // Read data captured in setup so prdata is a flop in the access cycle
    always_comb begin
        rdata_d = rdata_q;
        if (setupPhase && !pwrite) begin
            rdata_d = 32'h0000_0000;
            case (regSel)
                3'h1: rdata_d[ddc_preset_pkg::SOURCE_BIT] = presetSource_q;
                3'h2: rdata_d[2:0] = presetIndex_q;
                3'h3: rdata_d[15:0] = divisor_q;
                3'h4: begin
                    rdata_d[2:0] = active_q;
                    rdata_d[ddc_preset_pkg::STATUS_UNSURE_BIT] = unsure_q;
                    rdata_d[ddc_preset_pkg::STATUS_DIVHIGH_BIT] =
                        divisor_q > ddc_preset_pkg::DIVISOR_LIMIT;
                end
                default: rdata_d = 32'h0000_0000;
            endcase
        end
    end

    // Registers; pins pass through two flops before use
    always_ff @(posedge mclk) begin
        pinMeta_q <= presetSelectPins;
        pinSync_q <= pinMeta_q;
        if (rst) begin
            presetSource_q <= ddc_preset_pkg::SOURCE_RESET;
            presetIndex_q <= ddc_preset_pkg::INDEX_RESET;
            divisor_q <= ddc_preset_pkg::DIVISOR_RESET;
            active_q <= 3'h0;
            cfg_q <= '0;
            unsure_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
        end else begin
            presetSource_q <= presetSource_d;
            presetIndex_q <= presetIndex_d;
            divisor_q <= divisor_d;
            active_q <= active_d;
            cfg_q <= cfg_d;
            unsure_q <= unsure_d;
            rdata_q <= rdata_d;
        end
    end

    // Outputs straight from flops
    assign prdata = rdata_q;
    assign activePreset = active_q;
    assign activeCfg = cfg_q;
    assign rationalStepDivisor = divisor_q;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    a_pin_source: assert property (
        !presetSource_q |=> active_q == $past(pinSync_q))
        else $error("pin source not followed");
    a_reg_source: assert property (
        presetSource_q |=> active_q == $past(presetIndex_q))
        else $error("register source not followed");
    a_index_write: assert property (
        wrEn && regSel == 3'h2 && pstrb[0]
        |=> presetIndex_q == $past(pwdata[2:0]))
        else $error("index write lost");
    a_freq_follow: assert property (
        1'b1 |=> cfg_q.frequencyWord
            == $past(presetTable[active_q].frequencyWord))
        else $error("frequency not from active preset");
    a_delay_follow: assert property (
        1'b1 |=> cfg_q.downconverterDelay
            == $past(presetTable[active_q].downconverterDelay))
        else $error("delay not from active preset");
    a_phase_justify: assert property (
        1'b1 |=> cfg_q.phaseOffset
            == {$past(presetTable[active_q].phaseOffset), 16'h0000})
        else $error("phase not MSB-justified");
    a_divisor_write: assert property (
        wrEn && regSel == 3'h3 && pstrb == 4'hf
        |=> divisor_q == $past(pwdata[15:0]))
        else $error("divisor write lost");
    a_pin_sync: assert property (
        !presetSource_q && $stable(presetSource_q)
        ##1 !presetSource_q |-> ##1 active_q == $past(presetSelectPins, 3))
        else $error("pin latency wrong");
    a_unsure_set: assert property (
        linkRunning && freqChange |=> unsure_q)
        else $error("phase flag not set");
    a_reset_clear: assert property (
        @(posedge mclk) disable iff (1'b0) rst
        |=> !presetSource_q && presetIndex_q == 3'h0 && divisor_q == 16'h0000)
        else $error("reset did not clear");

    c_pin_switch: cover property (!presetSource_q ##1 $changed(active_q));
    c_reg_switch: cover property (presetSource_q ##1 $changed(active_q));
    c_unsure_clear: cover property (unsure_q ##1 !unsure_q);
    c_slave_error: cover property (pslverr);

endmodule

// *** test/ddc_preset_select_config_tb.sv ***
// Self-checking bench for the preset select and divisor block.
// Assumes the design package is compiled first; APB master is local.
`timescale 1ns/1ps

module ddc_preset_select_config_tb;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [2:0] pinRequest = 3'h0;
    logic [2:0] presetSelectPins;
    logic linkRunning = 1'b0;
    ddc_preset_pkg::presetCfg_t presetTable [8];
    ddc_preset_pkg::presetIdx_t activePreset;
    ddc_preset_pkg::activeCfg_t activeCfg;
    logic [15:0] rationalStepDivisor;
    logic [31:0] rdata;
    logic rerr;
    int num_errors = 0;
    int total_checks = 0;
    // Worked step example in kHz: 3072 MHz sample rate, 10 kHz step
    localparam int SAMPLE_KHZ = 3072000;
    localparam int STEP_KHZ = 10;

    // ------------------------------------------------------------------
    // Clock, reset, table contents and instances
    // ------------------------------------------------------------------
    always #12.5 mclk = ~mclk;

    // Distinct values per preset so a wrong index cannot match
    initial begin
        for (int i = 0; i < 8; i++) begin
            presetTable[i].frequencyWord = 32'h1000_0003 * i + 32'h5;
            presetTable[i].phaseOffset = 16'(16'h1111 * i + 16'h2);
            presetTable[i].downconverterDelay = 8'h10 + 8'(i);
        end
    end

    ddc_preset_select_config u_ddc_preset_select_config (.mclk(mclk),
        .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr),
        .presetSelectPins(presetSelectPins), .linkRunning(linkRunning),
        .presetTable(presetTable), .activePreset(activePreset),
        .activeCfg(activeCfg), .rationalStepDivisor(rationalStepDivisor));

    preset_pin_driver u_preset_pin_driver (.mclk(mclk),
        .pinRequest(pinRequest), .presetSelectPins(presetSelectPins));

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic tally_and_finish;
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // One APB transfer; waits for pready, bounded, never a fixed count
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d, input logic [3:0] s = 4'hf);
        int n;
        n = 0;
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) begin
            chk(32'h1, 32'h0);
            tally_and_finish();
        end
    endtask

    task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0, 4'h0);
        chk(rdata, exp);
    endtask

    // Active outputs against the table entry of preset i
    task automatic cfgchk(input int i);
        chk(32'(activePreset), 32'(i));
        chk(activeCfg.frequencyWord, presetTable[i].frequencyWord);
        chk(activeCfg.phaseOffset,
            {presetTable[i].phaseOffset, 16'h0});
        chk(32'(activeCfg.downconverterDelay),
            32'(presetTable[i].downconverterDelay));
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic reset_values;
        rdchk(ddc_preset_pkg::PRESET_SOURCE_CONTROL_ADDR, 32'h0);
        rdchk(ddc_preset_pkg::PRESET_INDEX_SELECT_ADDR, 32'h0);
        rdchk(ddc_preset_pkg::RATIONAL_STEP_DIVISOR_ADDR, 32'h0);
        chk(32'(activePreset), 32'h0);
    endtask

    // Every pin code, through the synchroniser, drives the active preset
    task automatic pin_mode;
        for (int i = 7; i >= 0; i--) begin
            @(posedge mclk);
            pinRequest <= 3'(i);
            repeat (6) @(posedge mclk);
            cfgchk(i);
        end
    endtask

    // Software index wins over pins; reserved bits not kept
    task automatic software_mode;
        apb(1'b1, ddc_preset_pkg::PRESET_SOURCE_CONTROL_ADDR, 32'h1);
        apb(1'b1, ddc_preset_pkg::PRESET_INDEX_SELECT_ADDR, 32'hff);
        rdchk(ddc_preset_pkg::PRESET_INDEX_SELECT_ADDR, 32'h7);
        cfgchk(7);
        linkRunning <= 1'b1;
        apb(1'b1, ddc_preset_pkg::PRESET_INDEX_SELECT_ADDR, 32'h6);
        repeat (3) @(posedge mclk);
        cfgchk(6);
        rdchk(ddc_preset_pkg::PRESET_STATUS_ADDR, 32'h0e);
        linkRunning <= 1'b0;
        apb(1'b1, ddc_preset_pkg::PRESET_STATUS_ADDR, 32'h8);
        rdchk(ddc_preset_pkg::PRESET_STATUS_ADDR, 32'h06);
    endtask

    // Divisor width and lanes, the 8192 boundary, the software recipe,
    // and an unmapped place whose write must leave the divisor alone
    task automatic divisor_and_map;
        apb(1'b1, ddc_preset_pkg::RATIONAL_STEP_DIVISOR_ADDR, 32'h1234_2000);
        rdchk(ddc_preset_pkg::RATIONAL_STEP_DIVISOR_ADDR, 32'h2000);
        rdchk(ddc_preset_pkg::PRESET_STATUS_ADDR, 32'h06);
        chk(32'(rationalStepDivisor), 32'h2000);
        apb(1'b1, ddc_preset_pkg::RATIONAL_STEP_DIVISOR_ADDR, 32'h2001);
        rdchk(ddc_preset_pkg::PRESET_STATUS_ADDR, 32'h16);
        // Lane 0 only: the upper byte must survive
        apb(1'b1, ddc_preset_pkg::RATIONAL_STEP_DIVISOR_ADDR,
            32'h0000_55aa, 4'h1);
        rdchk(ddc_preset_pkg::RATIONAL_STEP_DIVISOR_ADDR, 32'h20aa);
        // Whole-number divisor from sample rate / step / 128
        apb(1'b1, ddc_preset_pkg::RATIONAL_STEP_DIVISOR_ADDR,
            32'(SAMPLE_KHZ / STEP_KHZ / 128));
        rdchk(ddc_preset_pkg::RATIONAL_STEP_DIVISOR_ADDR, 32'h0960);
        rdchk(ddc_preset_pkg::PRESET_STATUS_ADDR, 32'h06);
        apb(1'b1, 12'h844, 32'hffff_ffff);
        chk(32'(rerr), 32'h1);
        rdchk(12'h844, 32'h0);
        chk(32'(rerr), 32'h1);
        chk(32'(rationalStepDivisor), 32'h0960);
    endtask

    // Reset in mid-run: every field clears and the pins take over again
    task automatic reset_midrun;
        @(posedge mclk);
        rst <= 1'b1;
        pinRequest <= 3'h5;
        repeat (5) @(posedge mclk);
        rst <= 1'b0;
        rdchk(ddc_preset_pkg::PRESET_SOURCE_CONTROL_ADDR, 32'h0);
        rdchk(ddc_preset_pkg::PRESET_INDEX_SELECT_ADDR, 32'h0);
        rdchk(ddc_preset_pkg::RATIONAL_STEP_DIVISOR_ADDR, 32'h0);
        chk(32'(rationalStepDivisor), 32'h0);
        cfgchk(5);
        rdchk(ddc_preset_pkg::PRESET_STATUS_ADDR, 32'h05);
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (5) @(posedge mclk);
        rst <= 1'b0;
        reset_values();
        pin_mode();
        software_mode();
        divisor_and_map();
        reset_midrun();
        tally_and_finish();
    end
endmodule

// *** test/preset_pin_driver.sv ***
// Model of the neighbour logic that drives the three preset select pins.
// Assumes the bench asks for a pin value; the model launches it on mclk.
`timescale 1ns/1ps

// ------------------------------------------------------------------
// Pin driver
// ------------------------------------------------------------------
module preset_pin_driver (
    input wire logic mclk,
    input wire logic [2:0] pinRequest,
    output logic [2:0] presetSelectPins
);
    // Registered launch, so pins move just after an edge like real logic
    always_ff @(posedge mclk) begin
        presetSelectPins <= pinRequest;
    end
endmodule
